// ---- rtl/jack_pkg.sv ----
package jack_pkg;

   // Register byte offsets
   localparam logic [4:0] CLOCK_CTRL_OFS = 5'h00;
   localparam logic [4:0] PIN_CTRL_OFS   = 5'h04;
   localparam logic [4:0] JACK_CFG_OFS   = 5'h08;
   localparam logic [4:0] JACK_MAP_OFS   = 5'h0c;
   localparam logic [4:0] POWER_OFS      = 5'h10;
   localparam logic [4:0] STATE_OFS      = 5'h14;
   localparam logic [4:0] IRQ_STATUS_OFS = 5'h18;
   localparam logic [4:0] IRQ_MASK_OFS   = 5'h1c;

   // Field positions
   localparam int TICK_EN_BIT    = 0;
   localparam int RATE_LSB       = 1;
   localparam int PIN_OE_BIT     = 0;
   localparam int PIN_OUT_BIT    = 1;
   localparam int SEL_LSB        = 0;
   localparam int DETECT_EN_BIT  = 2;
   localparam int JACK_BIAS_BIT  = 3;
   localparam int MAP_HI_LSB     = 0;
   localparam int MAP_LO_LSB     = 4;
   localparam int SW_BIAS_BIT    = 0;
   localparam int NORMAL_EN_LSB  = 1;
   localparam int NUM_OUTPUTS    = 4;
   localparam int IRQ_TICK_BIT   = 0;
   localparam int IRQ_INSERT_BIT = 1;
   localparam int IRQ_REMOVE_BIT = 2;
   localparam int NUM_IRQ        = 3;

   // Reset values
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // Sense pin selection codes
   localparam logic [1:0] SEL_MULTI_FUNCTION = 2'h0;
   localparam logic [1:0] SEL_LEFT_LINE      = 2'h1;
   localparam logic [1:0] SEL_RIGHT_LINE     = 2'h2;

   // Slow tick timing
   localparam int unsigned TICK_PERIOD_US  = 128000;
   localparam int unsigned CONV_CLK_PER_FS = 256;
   localparam int          STABLE_TICKS    = 3;
   localparam int          COUNT_W         = 24;

   typedef struct packed {
      logic       bias_en;
      logic       detect_en;
      logic [1:0] pin_sel;
   } jack_cfg_t;

   typedef struct packed {
      logic [NUM_OUTPUTS-1:0] when_low;
      logic [NUM_OUTPUTS-1:0] when_high;
   } jack_map_t;

   // Converter clock pulses in one tick for an indicated rate in kHz
   function automatic logic [COUNT_W-1:0] tick_count(input int unsigned us,
                                                     input int unsigned khz);
      longint unsigned t;
      t = longint'(us) * CONV_CLK_PER_FS * khz / 1000;
      if (t == 0)
         t = 1;
      return t[COUNT_W-1:0];
   endfunction : tick_count

endpackage : jack_pkg

// ---- rtl/slow_tick_gen.sv ----
`timescale 1ns/1ps
module slow_tick_gen
   import jack_pkg::*;
#(
   parameter int unsigned TICK_US = TICK_PERIOD_US
)
(
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   // Control
   input  wire logic       i_enable,
   input  wire logic [2:0] i_rate_code,
   input  wire logic       i_conv_clk_en,
   // Tick
   output logic            o_tick
);

   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] limit;

   // Divider follows the indicated rate only; real rate shifts the period
   always_comb
   begin
      unique case (i_rate_code)
         3'h0:    limit = tick_count(TICK_US, 48);
         3'h1:    limit = tick_count(TICK_US, 32);
         3'h2:    limit = tick_count(TICK_US, 24);
         3'h3:    limit = tick_count(TICK_US, 16);
         3'h4:    limit = tick_count(TICK_US, 12);
         default: limit = tick_count(TICK_US, 8);
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !i_enable)
      begin
         count  <= '0;
         o_tick <= 1'b0;
      end
      else
      begin
         o_tick <= 1'b0;
         if (i_conv_clk_en)
         begin
            // >= so a raised rate code does not strand the count
            if (count >= limit - 1'b1)
            begin
               count  <= '0;
               o_tick <= 1'b1;
            end
            else
               count <= count + 1'b1;
         end
      end
   end

endmodule : slow_tick_gen

// ---- rtl/jack_debounce.sv ----
`timescale 1ns/1ps
module jack_debounce
   import jack_pkg::*;
(
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   // Control
   input  wire logic i_enable,
   input  wire logic i_tick,
   input  wire logic i_sense,
   // Result
   output logic      o_jack
);

   logic       sync_a;
   logic       sync_b;
   logic       candidate;
   logic [1:0] seen;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end
      else
      begin
         sync_a <= i_sense;
         sync_b <= sync_a;
      end
   end

   // Sampled only on ticks, so pin timing jitters within a tick
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !i_enable)
      begin
         o_jack    <= 1'b0;
         candidate <= 1'b0;
         seen      <= 2'h0;
      end
      else if (i_tick)
      begin
         if (sync_b == o_jack)
            seen <= 2'h0;
         else if (seen != 2'h0 && sync_b == candidate)
         begin
            if (seen == 2'(STABLE_TICKS - 1))
            begin
               o_jack <= candidate;
               seen   <= 2'h0;
            end
            else
               seen <= seen + 2'h1;
         end
         else
         begin
            candidate <= sync_b;
            seen      <= 2'h1;
         end
      end
   end

endmodule : jack_debounce

// ---- rtl/jack_detect_debounce_timer.sv ----
// Operation
// - Slow tick serves volume timeout and jack debounce; software enables it.
// - Tick generator is off after reset until its enable bit is set.
// - Tick divides converter clock per indicated rate for a 128 ms period.
// - Wrong rate indication scales the tick period proportionally, uncorrected.
// - Rate indication scales only internal timing, never actual sampling rate.
// - Multi-function pin is in or out; line sense pins are input only.
// - Jack detection watches exactly one pin chosen by a select field.
// - Persistent change updates jack signal in 2.5 to 3.5 ticks; glitches ignored.
// - Debounce timed by the free tick, so detection latency jitters.
// - Bias enable is software bit OR jack signal when jack bias on.
// - Four outputs individually jack-linked: headphone, speaker, two auxiliaries.
// - Effective output enable is jack-derived enable AND normal enable.
// - One output map applies while jack is 1, another while 0.
// - Jack config holds pin select, detection enable, jack bias enable.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module jack_detect_debounce_timer
   import jack_pkg::*;
#(
   parameter int unsigned TICK_US = TICK_PERIOD_US
)
(
   // Clock and reset
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst,
   // Avalon-MM slave
   input  wire logic [4:0]             i_address,
   input  wire logic                   i_read,
   input  wire logic                   i_write,
   input  wire logic [31:0]            i_writedata,
   input  wire logic [3:0]             i_byteenable,
   output logic [31:0]                 o_readdata,
   output logic                        o_waitrequest,
   output logic                        o_irq,
   // Converter clock enable, 256 pulses per real sample
   input  wire logic                   i_internal_converter_clock_en,
   // Pins
   input  wire logic                   i_multi_function_pin,
   output logic                        o_multi_function_pin,
   output logic                        o_multi_function_pin_oe,
   input  wire logic                   i_left_line_sense_pin,
   input  wire logic                   i_right_line_sense_pin,
   // Power controls
   output logic                        o_analog_bias_enable,
   output logic [NUM_OUTPUTS-1:0]      o_output_enable,
   output logic                        o_slow_tick
);

   logic                   tick_en;
   logic [2:0]             rate_code;
   logic                   pin_oe;
   logic                   pin_out;
   jack_cfg_t              cfg;
   jack_map_t              map;
   logic                   sw_bias;
   logic [NUM_OUTPUTS-1:0] normal_en;
   logic [NUM_IRQ-1:0]     irq_status;
   logic [NUM_IRQ-1:0]     irq_mask;
   logic                   tick;
   logic                   jack;
   logic                   jack_d;
   logic                   sense;
   logic                   wr_go;
   logic [31:0]            wmask;
   logic [31:0]            wdata;
   logic [31:0]            next_readdata;
   logic [NUM_IRQ-1:0]     events;
   logic [NUM_OUTPUTS-1:0] jack_sel_en;
   logic                   jack_raw;
   logic                   mid_tick;
   logic [31:0]            tick_gap;
   logic [31:0]            gap_half;

   // One wait cycle: request seen, then waitrequest low for one edge
   assign wr_go = i_write && !o_waitrequest;

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         wmask[8*b +: 8] = {8{i_byteenable[b]}};
   end

   assign wdata = i_writedata & wmask;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         o_waitrequest <= 1'b1;
      else
         o_waitrequest <= !((i_read || i_write) && o_waitrequest);
   end

   // Tick enable and rate indication; rate feeds no converter clock
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         tick_en   <= REG_RESET[TICK_EN_BIT];
         rate_code <= REG_RESET[RATE_LSB +: 3];
      end
      else if (wr_go && i_address == CLOCK_CTRL_OFS)
      begin
         tick_en   <= (tick_en & ~wmask[TICK_EN_BIT]) | wdata[TICK_EN_BIT];
         rate_code <= (rate_code & ~wmask[RATE_LSB +: 3]) | wdata[RATE_LSB +: 3];
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         pin_oe  <= REG_RESET[PIN_OE_BIT];
         pin_out <= REG_RESET[PIN_OUT_BIT];
      end
      else if (wr_go && i_address == PIN_CTRL_OFS)
      begin
         pin_oe  <= (pin_oe & ~wmask[PIN_OE_BIT]) | wdata[PIN_OE_BIT];
         pin_out <= (pin_out & ~wmask[PIN_OUT_BIT]) | wdata[PIN_OUT_BIT];
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         cfg <= jack_cfg_t'(REG_RESET[3:0]);
      else if (wr_go && i_address == JACK_CFG_OFS)
         cfg <= jack_cfg_t'((cfg & ~wmask[3:0]) | wdata[3:0]);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         map <= jack_map_t'(REG_RESET[7:0]);
      else if (wr_go && i_address == JACK_MAP_OFS)
         map <= jack_map_t'((map & ~wmask[7:0]) | wdata[7:0]);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         sw_bias   <= REG_RESET[SW_BIAS_BIT];
         normal_en <= REG_RESET[NORMAL_EN_LSB +: NUM_OUTPUTS];
      end
      else if (wr_go && i_address == POWER_OFS)
      begin
         sw_bias   <= (sw_bias & ~wmask[SW_BIAS_BIT]) | wdata[SW_BIAS_BIT];
         normal_en <= (normal_en & ~wmask[NORMAL_EN_LSB +: NUM_OUTPUTS])
                      | wdata[NORMAL_EN_LSB +: NUM_OUTPUTS];
      end
   end

   slow_tick_gen #(
      .TICK_US (TICK_US)
   ) u_tick (
      .i_ref_clk     (i_ref_clk),
      .i_rst         (i_rst),
      .i_enable      (tick_en),
      .i_rate_code   (rate_code),
      .i_conv_clk_en (i_internal_converter_clock_en),
      .o_tick        (tick)
   );

   // Exactly one pin feeds the debouncer; code 3 reads low
   always_comb
   begin
      unique case (cfg.pin_sel)
         SEL_MULTI_FUNCTION: sense = i_multi_function_pin;
         SEL_LEFT_LINE:      sense = i_left_line_sense_pin;
         SEL_RIGHT_LINE:     sense = i_right_line_sense_pin;
         default:            sense = 1'b0;
      endcase
   end

   // Clocks since the last internal tick; saturates while the tick is late
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !tick_en || tick)
         tick_gap <= 32'h0000_0000;
      else if (tick_gap != 32'h7fff_ffff)
         tick_gap <= tick_gap + 32'h0000_0001;
   end

   // Half of the last measured period; all ones never matches, so no
   // mid-point strobe comes before one full period has been seen
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !tick_en)
         gap_half <= 32'hffff_ffff;
      else if (tick)
         gap_half <= (tick_gap + 32'h0000_0001) >> 1;
   end

   // Debouncer samples midway between ticks and its result moves on the
   // next tick: detection lands 2.5 to 3.5 periods after a change
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !tick_en)
         mid_tick <= 1'b0;
      else
         mid_tick <= (tick_gap == gap_half);
   end

   // Detection without the tick would freeze; needs both enables
   jack_debounce u_debounce (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_enable  (cfg.detect_en),
      .i_tick    (mid_tick),
      .i_sense   (sense),
      .o_jack    (jack_raw)
   );

   // Debounced level reaches status and power controls only on a tick,
   // half a period after the third agreeing sample
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !cfg.detect_en)
         jack <= 1'b0;
      else if (tick)
         jack <= jack_raw;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         jack_d <= 1'b0;
      else
         jack_d <= jack;
   end

   assign events[IRQ_TICK_BIT]   = tick;
   assign events[IRQ_INSERT_BIT] = jack && !jack_d;
   assign events[IRQ_REMOVE_BIT] = !jack && jack_d;

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         irq_status <= '0;
      else if (wr_go && i_address == IRQ_STATUS_OFS)
         irq_status <= (irq_status & ~wdata[NUM_IRQ-1:0]) | events;
      else
         irq_status <= irq_status | events;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         irq_mask <= '0;
      else if (wr_go && i_address == IRQ_MASK_OFS)
         irq_mask <= (irq_mask & ~wmask[NUM_IRQ-1:0]) | wdata[NUM_IRQ-1:0];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         o_irq <= 1'b0;
      else
         o_irq <= |(irq_status & irq_mask);
   end

   // Per output: map by jack level, then gate with the normal enable
   generate
      for (genvar g = 0; g < NUM_OUTPUTS; g++)
      begin : g_out
         // Detection off leaves the normal enable in sole control
         assign jack_sel_en[g] = !cfg.detect_en
                                 || (jack ? map.when_high[g] : map.when_low[g]);
         always_ff @(posedge i_ref_clk)
         begin
            if (i_rst)
               o_output_enable[g] <= 1'b0;
            else
               o_output_enable[g] <= jack_sel_en[g] && normal_en[g];
         end
      end
   endgenerate

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_analog_bias_enable    <= 1'b0;
         o_multi_function_pin    <= 1'b0;
         o_multi_function_pin_oe <= 1'b0;
         o_slow_tick             <= 1'b0;
      end
      else
      begin
         o_analog_bias_enable    <= sw_bias || (cfg.bias_en && jack);
         // Only this pin can drive; line sense pins have no output path
         o_multi_function_pin    <= pin_out;
         o_multi_function_pin_oe <= pin_oe && !(cfg.detect_en
                                    && cfg.pin_sel == SEL_MULTI_FUNCTION);
         o_slow_tick             <= tick;
      end
   end

   always_comb
   begin
      next_readdata = 32'h0000_0000;
      unique case (i_address)
         CLOCK_CTRL_OFS:
         begin
            next_readdata[TICK_EN_BIT]    = tick_en;
            next_readdata[RATE_LSB +: 3]  = rate_code;
         end
         PIN_CTRL_OFS:
         begin
            next_readdata[PIN_OE_BIT]  = pin_oe;
            next_readdata[PIN_OUT_BIT] = pin_out;
         end
         JACK_CFG_OFS:   next_readdata[3:0] = cfg;
         JACK_MAP_OFS:   next_readdata[7:0] = map;
         POWER_OFS:
         begin
            next_readdata[SW_BIAS_BIT]                 = sw_bias;
            next_readdata[NORMAL_EN_LSB +: NUM_OUTPUTS] = normal_en;
         end
         STATE_OFS:
         begin
            next_readdata[0]   = jack;
            next_readdata[1]   = i_multi_function_pin;
            next_readdata[2]   = i_left_line_sense_pin;
            next_readdata[3]   = i_right_line_sense_pin;
            next_readdata[4]   = o_analog_bias_enable;
            next_readdata[8:5] = o_output_enable;
         end
         IRQ_STATUS_OFS: next_readdata[NUM_IRQ-1:0] = irq_status;
         IRQ_MASK_OFS:   next_readdata[NUM_IRQ-1:0] = irq_mask;
         default:        next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         o_readdata <= 32'h0000_0000;
      else if (i_read && o_waitrequest)
         o_readdata <= next_readdata;
   end

endmodule : jack_detect_debounce_timer

// ---- verification/jack_switch_model.sv ----
`timescale 1ns/1ps
module jack_switch_model
(
   // Clock
   input  wire logic i_ref_clk,
   // Plug state commanded by the bench
   input  wire logic i_plug,
   // Switch contact
   output logic      o_contact
);
   logic last;
   int   bounce;

   initial
   begin
      o_contact = 1'b0;
      last      = 1'b0;
      bounce    = 0;
   end

   // Contact chatters a few cycles on each plug movement
   always @(posedge i_ref_clk)
   begin
      if (i_plug !== last)
      begin
         last      <= i_plug;
         bounce    <= 6;
         o_contact <= ~o_contact;
      end
      else if (bounce > 0)
      begin
         bounce    <= bounce - 1;
         o_contact <= ~o_contact;
      end
      else
         o_contact <= last;
   end
endmodule : jack_switch_model

// ---- verification/jack_monitor.sv ----
`timescale 1ns/1ps
module jack_monitor
   import jack_pkg::*;
#(
   parameter int unsigned TICK_US = TICK_PERIOD_US
)
(
   input wire logic                   i_ref_clk,
   input wire logic                   i_rst,
   input wire logic                   i_read,
   input wire logic                   i_write,
   input wire logic                   o_waitrequest,
   input wire logic                   o_irq,
   input wire logic                   o_multi_function_pin_oe,
   input wire logic                   o_analog_bias_enable,
   input wire logic [NUM_OUTPUTS-1:0] o_output_enable,
   input wire logic                   o_slow_tick
);
   // Recent tick or write: the only legal causes of an output change
   logic [5:0] hist;
   logic       cause;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         hist <= '0;
      else
         hist <= {hist[4:0], o_slow_tick | i_write};
   end
   assign cause = (|hist) | o_slow_tick;

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_reset_quiet: assert property (@(posedge i_ref_clk) disable iff (1'b0)
      i_rst |=> o_waitrequest && !o_irq && !o_slow_tick && o_output_enable == '0)
      else $error("outputs not quiet after reset");
   a_wait_one: assert property ($fell(o_waitrequest) |=> o_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_req: assert property ($fell(o_waitrequest) |-> $past(i_read | i_write))
      else $error("waitrequest dropped without request");
   a_tick_pulse: assert property (o_slow_tick |=> !o_slow_tick)
      else $error("slow tick longer than one cycle");
   a_out_cause: assert property ($changed(o_output_enable) |-> cause)
      else $error("output enables changed without tick or write");
   a_bias_cause: assert property ($changed(o_analog_bias_enable) |-> cause)
      else $error("bias changed without tick or write");
   a_irq_cause: assert property ($changed(o_irq) |-> cause)
      else $error("irq changed without tick or write");
   a_oe_cause: assert property ($changed(o_multi_function_pin_oe) |-> |hist)
      else $error("pin drive changed without write");

   c_tick: cover property (o_slow_tick);
   c_irq: cover property ($rose(o_irq));
   c_out: cover property ($changed(o_output_enable));
endmodule : jack_monitor

bind jack_detect_debounce_timer jack_monitor #(.TICK_US(TICK_US)) mon (.i_ref_clk,
   .i_rst, .i_read, .i_write, .o_waitrequest, .o_irq, .o_multi_function_pin_oe,
   .o_analog_bias_enable, .o_output_enable, .o_slow_tick);

// ---- verification/test_jack_detect_debounce_timer.sv ----
`timescale 1ns/1ps
module test_jack_detect_debounce_timer
   import jack_pkg::*;
;
   logic clk, rst, rd, wr, wreq, irq, cen, mfp, mfp_oe, bias, tick, plug, contact;
   logic [4:0]  adr;
   logic [31:0] wd, rdata, q, m;
   logic [3:0]  be, oe, pw;
   logic [1:0]  sel;
   int miscompares, checks, seed, dv, cdiv, i, p, n, e, P;
   int kz[8] = '{48, 32, 24, 16, 12, 8, 8, 8};

   jack_detect_debounce_timer #(.TICK_US(10)) uut (.i_ref_clk(clk), .i_rst(rst),
      .i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd), .i_byteenable(be),
      .o_readdata(rdata), .o_waitrequest(wreq), .o_irq(irq),
      .i_internal_converter_clock_en(cen), .i_multi_function_pin(sel == 2'h0 ? contact : ~contact),
      .o_multi_function_pin(mfp), .o_multi_function_pin_oe(mfp_oe),
      .i_left_line_sense_pin(sel == 2'h1 ? contact : ~contact),
      .i_right_line_sense_pin(sel == 2'h2 ? contact : ~contact),
      .o_analog_bias_enable(bias), .o_output_enable(oe), .o_slow_tick(tick));
   jack_switch_model sw (.i_ref_clk(clk), .i_plug(plug), .o_contact(contact));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Real converter rate: one enable pulse every dv clocks
   always @(posedge clk)
   begin
      cdiv <= cdiv + 1;
      cen  <= (cdiv % dv) == 0;
   end

   task results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   task chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk

   task chkr(input int g, input int lo, input int hi);
      checks++;
      if (g < lo || g > hi)
      begin
         miscompares++;
         $display("mismatch at %0t: latency %0d outside %0d..%0d", $time, g, lo, hi);
         if (g >= 3000)
            results();
      end
   endtask : chkr

   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      adr <= a;
      wr  <= w;
      rd  <= !w;
      wd  <= d;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 3000);
      chkr(k, 2, 2);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task period;
      repeat (2)
      begin
         p = 0;
         do
         begin
            @(posedge clk);
            p++;
         end while (tick !== 1'b1 && p < 3000);
      end
   endtask : period

   task wait_bias(input logic x);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (bias !== x && n < 3000);
      chkr(n, 5 * P / 2, 7 * P / 2 + 20);
   endtask : wait_bias

   initial
   begin
      seed = 12;
      {rst, rd, wr, plug, cen} = 5'h10;
      {adr, wd, sel, cdiv} = '0;
      be = 4'hf;
      dv = 2;
      P = 244;
      miscompares = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 8; i++)
      begin
         bus(1'b0, 5'(i * 4), 32'h0);
         chk(q, (i == 5) ? 32'h0000_000c : REG_RESET);
      end
      n = 0;
      repeat (600)
      begin
         @(posedge clk);
         n += (tick === 1'b1);
      end
      chk(n, 0);
      // Tick period follows the indicated rate; codes 5 to 7 alike at 8 kHz
      for (i = 0; i < 8; i++)
      begin
         bus(1'b1, CLOCK_CTRL_OFS, {28'h0, i[2:0], 1'b1});
         period();
         e = 2 * (10 * 256 * kz[i] / 1000);
         chkr(p, e, e);
      end
      bus(1'b1, CLOCK_CTRL_OFS, 32'h1);
      dv = 3;
      period();
      chkr(p, 366, 366);
      dv = 2;
      period();
      bus(1'b1, JACK_CFG_OFS, 32'hd);
      bus(1'b1, PIN_CTRL_OFS, 32'h3);
      repeat (3) @(posedge clk);
      chk({mfp_oe, mfp}, 2'b11);
      bus(1'b1, JACK_CFG_OFS, 32'hc);
      repeat (3) @(posedge clk);
      chk(mfp_oe, 1'b0);
      bus(1'b1, IRQ_MASK_OFS, 32'h2);
      for (i = 0; i < 3; i++)
      begin
         m = $random(seed);
         pw = $random(seed);
         sel <= i[1:0];
         bus(1'b1, JACK_CFG_OFS, {28'h0, 2'b11, i[1:0]});
         bus(1'b1, JACK_MAP_OFS, {24'h0, m[7:0]});
         bus(1'b1, POWER_OFS, {27'h0, pw, 1'b0});
         bus(1'b1, IRQ_STATUS_OFS, 32'h7);
         plug <= 1'b1;
         wait_bias(1'b1);
         repeat (2) @(posedge clk);
         chk(oe, m[3:0] & pw);
         repeat (2) @(posedge clk);
         chk(irq, 1'b1);
         bus(1'b1, IRQ_STATUS_OFS, 32'h2);
         repeat (3) @(posedge clk);
         chk(irq, 1'b0);
         plug <= 1'b0;
         repeat (20 + ($random(seed) & 63)) @(posedge clk);
         plug <= 1'b1;
         repeat (4 * P) @(posedge clk);
         chk({bias, oe}, {1'b1, m[3:0] & pw});
         plug <= 1'b0;
         wait_bias(1'b0);
         repeat (4) @(posedge clk);
         chk({irq, oe}, {1'b0, m[7:4] & pw});
         bus(1'b0, IRQ_STATUS_OFS, 32'h0);
         chk(q[2:1], 2'b10);
      end
      bus(1'b1, POWER_OFS, 32'h1);
      repeat (3) @(posedge clk);
      chk(bias, 1'b1);
      bus(1'b1, JACK_CFG_OFS, 32'h6);
      bus(1'b1, POWER_OFS, 32'h0);
      plug <= 1'b1;
      repeat (4 * P) @(posedge clk);
      chk(bias, 1'b0);
      bus(1'b0, STATE_OFS, 32'h0);
      chk(q[0], 1'b1);
      results();
   end
endmodule : test_jack_detect_debounce_timer
